// ===== bench/prh_heart_model.sv
// heart model: atrial and ventricular sense channels of the timer
// assumes one-cycle shots from the bench on the ref_clk domain
`timescale 1ns/100ps
module prh_heart_model
	import prh_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [15:0] v_per,
	input  wire logic        shot_a,
	input  wire logic        shot_v,
	input  wire logic        shot_pvc,
	output prh_sense_t       sense
);
	// ************************************************************
	// intrinsic rhythm
	// ************************************************************
	logic [15:0] cnt_q;
	logic        beat;

	// period 0 means no intrinsic ventricular rhythm at all
	assign beat = (v_per != 16'h0000) && (cnt_q >= v_per - 16'h0001);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_q <= 16'h0000;
			sense <= '0;
		end else begin
			cnt_q         <= beat ? 16'h0000 : cnt_q + 16'h0001;
			sense.a_sense <= shot_a;
			sense.v_sense <= beat | shot_v | shot_pvc;
			sense.v_pvc   <= shot_pvc;
		end
	end
endmodule : prh_heart_model

// ===== bench/tb_prh_pacing_timer.sv
// self-checking bench of the pacing timer with a heart model
// assumes TICK_CYC of 4, so one ms lasts four ref_clk cycles
`timescale 1ns/100ps
module tb_prh_pacing_timer
	import prh_pkg::*;
;
	typedef struct {
		bit          wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic        er;
	} prh_row_t;
	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] pts;
		int          stim;
		logic [15:0] e1;
		logic [15:0] e2;
	} prh_av_t;

	logic         ref_clk = 1'b0;
	logic         reset = 1'b1;
	prh_apb_req_t apb_req = '0;
	prh_apb_rsp_t apb_rsp;
	prh_sense_t   sense;
	logic         a_pace;
	logic         v_pace;
	logic [15:0]  esc_int;
	logic [15:0]  av_delay;
	logic [15:0]  v_per = 16'h0000;
	logic         shot_a = 1'b0;
	logic         shot_v = 1'b0;
	logic         shot_pvc = 1'b0;
	int           error_cnt = 0;
	int           comparisons = 0;
	int           n;
	int           k;

	prh_row_t regs [20] = '{
		'{0, OFS_CTRL, 0, 32'h0000_0000, 0},
		'{0, OFS_BASIC, 0, 32'h0000_03E8, 0},
		'{0, OFS_HYST, 0, 32'h0000_04B0, 0},
		'{0, OFS_SENSOR, 0, 32'h0000_03E8, 0},
		'{0, OFS_AV_FIX, 0, 32'h0000_0096, 0},
		'{0, OFS_AV_PTS, 0, 32'h0078_00B4, 0},
		'{0, OFS_RATE_PT, 0, 32'h01F4_03E8, 0},
		'{0, OFS_AV_ADJ, 0, 32'h001E_0032, 0},
		'{0, 8'h30, 0, 32'h0000_0000, 1},
		'{1, 8'h30, 32'h0000_0001, 32'h0000_0000, 1},
		'{1, OFS_ESC, 32'h0000_0005, 32'h0000_0000, 0},
		'{0, OFS_ESC, 0, 32'h0000_03E8, 0},
		'{1, OFS_CTRL, 32'h0000_0155, 32'h0000_0000, 0},
		'{0, OFS_CTRL, 0, 32'h0000_0155, 0},
		'{1, OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 0},
		'{1, OFS_BASIC, 32'h0000_0014, 32'h0000_0000, 0},
		'{1, OFS_HYST, 32'h0000_001E, 32'h0000_0000, 0},
		'{1, OFS_AV_FIX, 32'h0000_0005, 32'h0000_0000, 0},
		'{1, OFS_AV_ADJ, 32'h0002_0003, 32'h0000_0000, 0},
		'{0, OFS_BASIC, 0, 32'h0000_0014, 0}
	};

	// basic 250 ms sits midway between rate points 300 and 200 ms
	prh_av_t avs [11] = '{
		'{32'h0004, 32'h0003_0009, 0, 16'h0005, 0},
		'{32'h0104, 32'h0003_0009, 0, 16'h0064, 0},
		'{32'h0204, 32'h0003_0009, 0, 16'h0082, 0},
		'{32'h0304, 32'h0003_0009, 0, 16'h00A0, 0},
		'{32'h0404, 32'h0003_0009, 0, 16'h0006, 0},
		'{32'h0404, 32'h0009_0003, 0, 16'h0006, 0},
		'{32'h000C, 32'h0003_0009, 1, 16'h0003, 0},
		'{32'h0004, 32'h0003_0009, 2, 16'h0005, 16'h0005},
		'{32'h0014, 32'h0003_0009, 2, 16'h0008, 16'h0005},
		'{32'h0024, 32'h0003_0009, 2, 16'h0002, 16'h0005},
		'{32'h0014, 32'h0003_0009, 3, 16'h0005, 16'h0005}
	};

	prh_pacing_timer #(.TICK_CYC(4)) u_prh_pacing_timer (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.apb_req  (apb_req),
		.apb_rsp  (apb_rsp),
		.sense    (sense),
		.a_pace   (a_pace),
		.v_pace   (v_pace),
		.esc_int  (esc_int),
		.av_delay (av_delay)
	);

	prh_heart_model u_prh_heart_model (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.v_per    (v_per),
		.shot_a   (shot_a),
		.shot_v   (shot_v),
		.shot_pvc (shot_pvc),
		.sense    (sense)
	);

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic finish_test();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	task automatic timeout();
		error_cnt++;
		$display("mismatch at %0t: wait timed out", $time);
		finish_test();
	endtask : timeout

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int v, input int lo, input int hi);
		comparisons++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("mismatch at %0t: %0d not in %0d..%0d", $time, v, lo, hi);
		end
	endtask : chk_rng

	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : cyc

	// holds the request until pready is seen at a rising edge
	task automatic apb(input prh_row_t r);
		int i;
		apb_req <= '{1'b1, 1'b0, r.wr, r.a, r.d};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (apb_rsp.pready !== 1'b1 && i < 50);
		if (i >= 50) timeout();
		chk(apb_rsp.prdata, r.e);
		chk({31'h0, apb_rsp.pslverr}, {31'h0, r.er});
		apb_req <= '0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb('{1'b1, a, d, 32'h0, 1'b0});
	endtask : wr

	// cycles until the next ventricular (v=1) or atrial pace
	task automatic wp(input bit v, output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while ((v ? v_pace : a_pace) !== 1'b1 && c < 5000);
		if (c >= 5000) timeout();
	endtask : wp

	task automatic shot(input int s);
		case (s)
			1: shot_a <= 1'b1;
			2: shot_v <= 1'b1;
			default: shot_pvc <= 1'b1;
		endcase
		@(posedge ref_clk);
		{shot_a, shot_v, shot_pvc} <= 3'b000;
	endtask : shot

	task automatic no_vp(input int c);
		k = 0;
		repeat (c) begin
			@(posedge ref_clk);
			if (v_pace !== 1'b0) k++;
		end
	endtask : no_vp

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		cyc(6);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk({16'h0, esc_int}, 32'h0000_03E8);
		chk({16'h0, av_delay}, 32'h0000_0096);
		// av kept short of conduction by the rows below
		foreach (regs[i]) apb(regs[i]);
		wp(1'b1, n);
		wp(1'b1, n);
		chk_rng(n, 80, 80);
		chk({16'h0, esc_int}, 32'h0000_0014);
		v_per <= 16'd60;
		no_vp(400);
		chk_rng(k, 0, 0);
		v_per <= 16'h0000;
		wr(OFS_CTRL, 32'h0000_0001);
		wp(1'b1, n);
		shot(2);
		wp(1'b1, n);
		chk_rng(n, 112, 128);
		wp(1'b1, n);
		chk_rng(n, 80, 80);
		chk({16'h0, esc_int}, 32'h0000_0014);
		wr(OFS_CTRL, 32'h0000_0003);
		wp(1'b1, n);
		k = 0;
		do begin
			wp(1'b1, n);
			k++;
		end while (n < 100 && k < 250);
		chk_rng(k, 170, 182);
		chk_rng(n, 120, 120);
		k = 1;
		do begin
			wp(1'b1, n);
			if (n > 100) k++;
		end while (n > 100 && k < 20);
		chk_rng(k, 10, 10);
		chk_rng(n, 80, 80);
		// one sense then silence: hysteresis wait plus ten repeats
		shot(2);
		k = 0;
		do begin
			wp(1'b1, n);
			if (n > 100) k++;
		end while (n > 100 && k < 20);
		chk_rng(k, 11, 11);
		wr(OFS_BASIC, 32'h0000_00FA);
		wr(OFS_RATE_PT, 32'h00C8_012C);
		foreach (avs[i]) begin
			wr(OFS_CTRL, avs[i].ctrl);
			wr(OFS_AV_PTS, avs[i].pts);
			wp(1'b1, n);
			if (avs[i].stim == 1) begin
				shot(1);
				cyc(3);
			end else begin
				wp(1'b0, n);
				cyc(2);
				if (avs[i].stim > 1) begin
					shot(avs[i].stim);
					no_vp(40);
					if (avs[i].stim == 2) chk_rng(k, 0, 0);
					wp(1'b0, n);
					cyc(2);
				end
			end
			chk({16'h0, av_delay}, {16'h0, avs[i].e1});
			if (avs[i].stim > 1) begin
				wp(1'b1, n);
				wp(1'b0, n);
				cyc(2);
				chk({16'h0, av_delay}, {16'h0, avs[i].e2});
			end
		end
		// short basic interval keeps the long paced run affordable
		wr(OFS_BASIC, 32'h0000_0014);
		wr(OFS_CTRL, 32'h0000_0054);
		k = 0;
		do begin
			wp(1'b0, n);
			cyc(2);
			k++;
		end while (av_delay != 16'h0008 && k < 250);
		chk_rng(k, 170, 190);
		k = 1;
		do begin
			wp(1'b0, n);
			cyc(2);
			if (av_delay == 16'h0008) k++;
		end while (av_delay == 16'h0008 && k < 20);
		chk_rng(k, 5, 5);
		chk({16'h0, av_delay}, 32'h0000_0005);
		finish_test();
	end
endmodule : tb_prh_pacing_timer

// ===== rtl/prh_pacing_timer.sv
// rate hysteresis and av delay timer of the pacing engine, apb slave
// assumes sense inputs are one-cycle pulses, already non-refractory
//
// Notes on behaviour
// - sense restarts interval, else pace at expiry
// - after sense wait hysteresis interval
// - hysteresis expiry paces, then basic/sensor interval
// - 180 paced cycles trigger ten hysteresis cycles
// - rate scan and repetitive share one enable
// - lost rhythm paces hysteresis rate ten cycles
// - sense during hysteresis cycles inhibits pace
// - failed scan resumes basic or sensor rate
// - ventricular sense within av cancels pace
// - av delay interpolated between two rate points
// - preset, individual or fixed av curves
// - atrial sense shortens av by compensation
// - ventricular sense extends av delay
// - ventricular pace restores short av delay
// - 180 paced cycles extend av five cycles
// - failed av scan returns short, repeats
// - non-pvc ventricular sense restarts av count
// - av scan and repetitive share one enable
// - repetitive keeps extension five paced cycles
// - negative mode shortens av after sense
// - negative mode reverts after ventricular pace
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module prh_pacing_timer
	import prh_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire prh_apb_req_t apb_req,
	output prh_apb_rsp_t      apb_rsp,
	input  wire prh_sense_t   sense,
	output logic              a_pace,
	output logic              v_pace,
	output logic [15:0]       esc_int,
	output logic [15:0]       av_delay
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [10:0] ctrl;
		logic [15:0] basic;
		logic [15:0] hyst;
		logic [15:0] sensor;
		logic [15:0] av_fix;
		logic [15:0] av_lo;
		logic [15:0] av_hi;
		logic [15:0] int_lo;
		logic [15:0] int_hi;
		logic [15:0] av_hys;
		logic [15:0] sc;
		logic [31:0] tick;
		logic [15:0] esc_t;
		logic [15:0] esc_len;
		logic        hyst_wait;
		logic [3:0]  hcyc;
		logic [7:0]  pcnt;
		logic        av_on;
		logic [15:0] av_t;
		logic [15:0] av_len;
		logic [15:0] a_int_t;
		logic [15:0] a_int;
		logic        av_ext;
		logic [2:0]  av_rep;
		logic [7:0]  av_pcnt;
		logic        a_pace;
		logic        v_pace;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} prh_state_t;

	prh_state_t s_q;
	prh_state_t s_d;

	logic        tick;
	logic        dual;
	logic        rate_sense;
	logic        esc_exp;
	logic        av_exp;
	logic        scan_rep;
	logic        av_scan;
	logic        vs_int;
	logic        vp_ev;
	logic [15:0] base_int;
	logic [15:0] av_base;
	logic [3:0]  hcyc_n;
	logic [31:0] rd;
	logic        hit;

	// linear av delay between the slow and the fast rate point
	function automatic logic [15:0] interp(
		input logic [15:0] lo_av,
		input logic [15:0] hi_av,
		input logic [15:0] i_lo,
		input logic [15:0] i_hi,
		input logic [15:0] cur
	);
		int num;
		int den;
		num = 0;
		den = 0;
		if (cur >= i_lo || i_lo <= i_hi) begin
			return lo_av;
		end
		if (cur <= i_hi) begin
			return hi_av;
		end
		num = (int'(hi_av) - int'(lo_av)) * (int'(i_lo) - int'(cur));
		den = int'(i_lo) - int'(i_hi);
		return 16'(int'(lo_av) + num / den);
	endfunction : interp

	// clamp to at least one ms so a timer always runs
	function automatic logic [15:0] clamp1(input int v);
		if (v < 1) begin
			return 16'h0001;
		end
		if (v > 65535) begin
			return 16'hFFFF;
		end
		return 16'(v);
	endfunction : clamp1

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		int av_v;
		av_v = 0;
		s_d          = s_q;
		s_d.a_pace   = 1'b0;
		s_d.v_pace   = 1'b0;
		s_d.pready   = 1'b0;
		s_d.pslverr  = 1'b0;
		dual     = s_q.ctrl[CB_DUAL];
		// one bit each, so scan and repetitive cannot be split
		// shared rate enable
		scan_rep = s_q.ctrl[CB_RATE_SCAN];
		av_scan  = s_q.ctrl[CB_AV_SCAN];
		tick     = (s_q.tick == 32'(TICK_CYC - 1));
		s_d.tick = tick ? 32'h0000_0000 : s_q.tick + 32'h0000_0001;
		esc_exp  = tick && (s_q.esc_t + 16'h0001 >= s_q.esc_len);
		av_exp   = s_q.av_on && tick
			&& (s_q.av_t + 16'h0001 >= s_q.av_len);
		rate_sense = dual ? (sense.a_sense | (sense.v_sense & sense.v_pvc))
			: sense.v_sense;
		vs_int   = sense.v_sense & ~sense.v_pvc;
		base_int = s_q.ctrl[CB_SENSOR] ? s_q.sensor : s_q.basic;
		hcyc_n   = s_q.hcyc;
		if (tick) begin
			s_d.esc_t = s_q.esc_t + 16'h0001;
			s_d.av_t  = s_q.av_t + 16'h0001;
			if (s_q.a_int_t != 16'hFFFF) begin
				s_d.a_int_t = s_q.a_int_t + 16'h0001;
			end
		end

		// rate timing
		if (rate_sense) begin
			s_d.esc_t = 16'h0000;
			s_d.esc_len   = s_q.ctrl[CB_RATE_HYST] ? s_q.hyst : base_int;
			s_d.hyst_wait = s_q.ctrl[CB_RATE_HYST];
			s_d.hcyc = 4'h0;
			s_d.pcnt = 8'h00;
		end else if (esc_exp) begin
			s_d.esc_t = 16'h0000;
			if (dual) begin
				s_d.a_pace = 1'b1;
			end else begin
				s_d.v_pace = 1'b1;
			end
			if (s_q.hyst_wait && scan_rep) begin
				hcyc_n = RATE_REP_CYC;
			end else if (s_q.hcyc != 4'h0) begin
				hcyc_n = s_q.hcyc - 4'h1;
			end
			s_d.pcnt = s_q.pcnt + 8'h01;
			if (scan_rep && s_q.pcnt == SCAN_RUN - 8'h01) begin
				// scan after a long paced run
				hcyc_n   = RATE_REP_CYC;
				s_d.pcnt = 8'h00;
			end else if (s_q.pcnt == 8'hFF) begin
				s_d.pcnt = s_q.pcnt;
			end
			s_d.hcyc      = hcyc_n;
			s_d.hyst_wait = 1'b0;
			// hysteresis interval while repeat cycles remain, else basic or sensor
			s_d.esc_len   = (hcyc_n != 4'h0) ? s_q.hyst : base_int;
		end

		case (prh_curve_t'(s_q.ctrl[CB_CURVE_LSB +: 3]))
			CURVE_FIXED: av_base = s_q.av_fix;
			CURVE_LOW:   av_base = interp(PRE_LOW_LO, PRE_LOW_HI,
				s_q.int_lo, s_q.int_hi, s_q.a_int);
			CURVE_MED:   av_base = interp(PRE_MED_LO, PRE_MED_HI,
				s_q.int_lo, s_q.int_hi, s_q.a_int);
			CURVE_HIGH:  av_base = interp(PRE_HIGH_LO, PRE_HIGH_HI,
				s_q.int_lo, s_q.int_hi, s_q.a_int);
			CURVE_INDIV: av_base = interp(s_q.av_lo, s_q.av_hi,
				s_q.int_lo, s_q.int_hi, s_q.a_int);
			default:     av_base = s_q.av_fix;
		endcase

		// av timing, dual chamber only
		if (dual && (sense.a_sense || (esc_exp && !rate_sense))) begin
			av_v = int'(av_base);
			if (s_q.av_ext && s_q.ctrl[CB_AV_POS]) begin
				av_v = av_v + int'(s_q.av_hys);
			end else if (s_q.av_ext && s_q.ctrl[CB_AV_NEG]) begin
				av_v = av_v - int'(s_q.av_hys);
			end
			if (sense.a_sense && s_q.ctrl[CB_SENSE_CMP]) begin
				av_v = av_v - int'(s_q.sc);
			end
			s_d.av_on   = 1'b1;
			s_d.av_t    = 16'h0000;
			s_d.av_len  = clamp1(av_v);
			s_d.a_int   = s_q.a_int_t;
			s_d.a_int_t = 16'h0000;
		end else if (s_q.av_on && sense.v_sense) begin
			s_d.av_on = 1'b0;
		end else if (av_exp) begin
			s_d.av_on  = 1'b0;
			s_d.v_pace = 1'b1;
		end

		// av hysteresis
		vp_ev = av_exp && !sense.v_sense && !sense.a_sense;
		if (vs_int) begin
			s_d.av_pcnt = 8'h00;
			s_d.av_ext  = s_q.ctrl[CB_AV_POS] | s_q.ctrl[CB_AV_NEG];
			s_d.av_rep  = AV_REP_CYC;
		end else if (vp_ev) begin
			s_d.av_pcnt = s_q.av_pcnt + 8'h01;
			if (s_q.ctrl[CB_AV_POS] && av_scan && s_q.av_ext
				&& s_q.av_rep > 3'h1) begin
				s_d.av_rep = s_q.av_rep - 3'h1;
			end else begin
				s_d.av_ext = 1'b0;
				s_d.av_rep = 3'h0;
			end
			if (s_q.ctrl[CB_AV_POS] && av_scan
				&& s_q.av_pcnt == SCAN_RUN - 8'h01) begin
				s_d.av_ext  = 1'b1;
				s_d.av_rep  = AV_REP_CYC;
				s_d.av_pcnt = 8'h00;
			end
		end

		// ************************************************************
		// apb slave, one wait state
		// ************************************************************
		hit = 1'b1;
		case (apb_req.paddr)
			OFS_CTRL:    rd = {21'h0, s_q.ctrl};
			OFS_BASIC:   rd = {16'h0, s_q.basic};
			OFS_HYST:    rd = {16'h0, s_q.hyst};
			OFS_SENSOR:  rd = {16'h0, s_q.sensor};
			OFS_AV_FIX:  rd = {16'h0, s_q.av_fix};
			OFS_AV_PTS:  rd = {s_q.av_hi, s_q.av_lo};
			OFS_RATE_PT: rd = {s_q.int_hi, s_q.int_lo};
			OFS_AV_ADJ:  rd = {s_q.sc, s_q.av_hys};
			OFS_STATUS:  rd = {s_q.av_pcnt, s_q.pcnt, 5'h0, s_q.av_rep,
				s_q.hcyc, s_q.av_on, s_q.av_ext, s_q.hyst_wait, 1'b0};
			OFS_ESC:     rd = {16'h0, s_q.esc_len};
			OFS_AVD:     rd = {16'h0, s_q.av_len};
			default: begin
				rd  = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
		if (apb_req.psel && apb_req.penable && !s_q.pready) begin
			s_d.pready  = 1'b1;
			s_d.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
			s_d.pslverr = !hit;
		end
		if (apb_req.psel && apb_req.penable && s_q.pready
			&& apb_req.pwrite) begin
			case (apb_req.paddr)
				OFS_CTRL:    s_d.ctrl   = apb_req.pwdata[10:0];
				OFS_BASIC:   s_d.basic  = apb_req.pwdata[15:0];
				OFS_HYST:    s_d.hyst   = apb_req.pwdata[15:0];
				OFS_SENSOR:  s_d.sensor = apb_req.pwdata[15:0];
				OFS_AV_FIX:  s_d.av_fix = apb_req.pwdata[15:0];
				OFS_AV_PTS: begin
					s_d.av_lo = apb_req.pwdata[15:0];
					s_d.av_hi = apb_req.pwdata[31:16];
				end
				OFS_RATE_PT: begin
					s_d.int_lo = apb_req.pwdata[15:0];
					s_d.int_hi = apb_req.pwdata[31:16];
				end
				OFS_AV_ADJ: begin
					s_d.av_hys = apb_req.pwdata[15:0];
					s_d.sc     = apb_req.pwdata[31:16];
				end
				default: s_d.ctrl = s_q.ctrl;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q         <= '0;
			s_q.ctrl    <= RST_CTRL;
			s_q.basic   <= RST_BASIC;
			s_q.hyst    <= RST_HYST;
			s_q.sensor  <= RST_SENSOR;
			s_q.av_fix  <= RST_AV_FIX;
			s_q.av_lo   <= RST_AV_LO;
			s_q.av_hi   <= RST_AV_HI;
			s_q.int_lo  <= RST_INT_LO;
			s_q.int_hi  <= RST_INT_HI;
			s_q.av_hys  <= RST_AV_HYS;
			s_q.sc      <= RST_SC;
			s_q.esc_len <= RST_BASIC;
			s_q.av_len  <= RST_AV_FIX;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp  = '{pready: s_q.pready, prdata: s_q.prdata,
		pslverr: s_q.pslverr};
	assign a_pace   = s_q.a_pace;
	assign v_pace   = s_q.v_pace;
	assign esc_int  = s_q.esc_len;
	assign av_delay = s_q.av_len;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence seq_rate_run_end;
		esc_exp && !rate_sense && scan_rep
			&& s_q.pcnt == SCAN_RUN - 8'h01;
	endsequence
	sequence seq_av_run_end;
		vp_ev && !vs_int && s_q.ctrl[CB_AV_POS] && av_scan
			&& s_q.av_pcnt == SCAN_RUN - 8'h01;
	endsequence

	a_sense_restart: assert property (rate_sense |=> s_q.esc_t == 16'h0
		&& !a_pace && !v_pace)
		else $error("sense did not restart escape");
	a_hyst_len: assert property (rate_sense && s_q.ctrl[CB_RATE_HYST]
		|=> esc_int == $past(s_q.hyst))
		else $error("hysteresis interval not used");
	a_hyst_exit: assert property (esc_exp && !rate_sense && !scan_rep
		&& s_q.hcyc == 4'h0 |=> esc_int == $past(base_int))
		else $error("no return to base interval");
	a_scan_entry: assert property (seq_rate_run_end
		|=> s_q.hcyc == RATE_REP_CYC && esc_int == $past(s_q.hyst))
		else $error("rate scan not entered");
	a_cnt_clear: assert property (rate_sense |=> s_q.pcnt == 8'h0)
		else $error("paced count not cleared");
	a_rep_entry: assert property (esc_exp && !rate_sense && scan_rep
		&& s_q.hyst_wait |=> s_q.hcyc == RATE_REP_CYC)
		else $error("repetitive cycles not started");
	a_av_cancel: assert property (s_q.av_on && sense.v_sense
		&& !sense.a_sense && !(dual && esc_exp)
		|=> !s_q.av_on ##1 !v_pace)
		else $error("ventricular pace not cancelled");
	a_sc_short: assert property (dual && sense.a_sense
		&& s_q.ctrl[CB_SENSE_CMP] && !s_q.av_ext
		&& s_q.ctrl[CB_CURVE_LSB +: 3] == 3'b000
		&& s_q.av_fix > s_q.sc + 16'h1
		|=> av_delay == $past(s_q.av_fix) - $past(s_q.sc))
		else $error("sense compensation missing");
	a_av_extend: assert property (vs_int && s_q.ctrl[CB_AV_POS]
		|=> s_q.av_ext && s_q.av_pcnt == 8'h0)
		else $error("av delay not extended");
	a_av_short: assert property (vp_ev && !vs_int && !av_scan
		|=> !s_q.av_ext)
		else $error("short av delay not restored");
	a_av_scan: assert property (seq_av_run_end
		|=> s_q.av_ext && s_q.av_rep == AV_REP_CYC)
		else $error("av scan not entered");
	a_neg_revert: assert property (vp_ev && !vs_int
		&& s_q.ctrl[CB_AV_NEG] && !s_q.ctrl[CB_AV_POS]
		|=> !s_q.av_ext)
		else $error("negative hysteresis not reverted");

endmodule : prh_pacing_timer

// ===== rtl/prh_pkg.sv
// shared constants, register map and carrier types of the pacing timer
// assumes a 100 MHz ref_clk and a 1 ms timebase derived from it
package prh_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_NS       = 1000000;
	localparam int unsigned TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
	localparam logic [7:0]  SCAN_RUN      = 8'hB4;
	localparam logic [3:0]  RATE_REP_CYC  = 4'hA;
	localparam logic [2:0]  AV_REP_CYC    = 3'h5;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_BASIC   = 8'h04;
	localparam logic [7:0] OFS_HYST    = 8'h08;
	localparam logic [7:0] OFS_SENSOR  = 8'h0C;
	localparam logic [7:0] OFS_AV_FIX  = 8'h10;
	localparam logic [7:0] OFS_AV_PTS  = 8'h14;
	localparam logic [7:0] OFS_RATE_PT = 8'h18;
	localparam logic [7:0] OFS_AV_ADJ  = 8'h1C;
	localparam logic [7:0] OFS_STATUS  = 8'h20;
	localparam logic [7:0] OFS_ESC     = 8'h24;
	localparam logic [7:0] OFS_AVD     = 8'h28;

	localparam int unsigned CB_RATE_HYST = 0;
	localparam int unsigned CB_RATE_SCAN = 1;
	localparam int unsigned CB_DUAL      = 2;
	localparam int unsigned CB_SENSE_CMP = 3;
	localparam int unsigned CB_AV_POS    = 4;
	localparam int unsigned CB_AV_NEG    = 5;
	localparam int unsigned CB_AV_SCAN   = 6;
	localparam int unsigned CB_SENSOR    = 7;
	localparam int unsigned CB_CURVE_LSB = 8;

	// ************************************************************
	// reset values, ms
	// ************************************************************
	localparam logic [10:0] RST_CTRL    = 11'h000;
	localparam logic [15:0] RST_BASIC   = 16'h03E8;
	localparam logic [15:0] RST_HYST    = 16'h04B0;
	localparam logic [15:0] RST_SENSOR  = 16'h03E8;
	localparam logic [15:0] RST_AV_FIX  = 16'h0096;
	localparam logic [15:0] RST_AV_LO   = 16'h00B4;
	localparam logic [15:0] RST_AV_HI   = 16'h0078;
	localparam logic [15:0] RST_INT_LO  = 16'h03E8;
	localparam logic [15:0] RST_INT_HI  = 16'h01F4;
	localparam logic [15:0] RST_AV_HYS  = 16'h0032;
	localparam logic [15:0] RST_SC      = 16'h001E;

	// preset curves: av delay at the slow and at the fast rate point
	localparam logic [15:0] PRE_LOW_LO  = 16'h0078;
	localparam logic [15:0] PRE_LOW_HI  = 16'h0050;
	localparam logic [15:0] PRE_MED_LO  = 16'h00A0;
	localparam logic [15:0] PRE_MED_HI  = 16'h0064;
	localparam logic [15:0] PRE_HIGH_LO = 16'h00C8;
	localparam logic [15:0] PRE_HIGH_HI = 16'h0078;

	typedef enum logic [2:0] {
		CURVE_FIXED = 3'b000,
		CURVE_LOW   = 3'b001,
		CURVE_MED   = 3'b010,
		CURVE_HIGH  = 3'b011,
		CURVE_INDIV = 3'b100
	} prh_curve_t;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} prh_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} prh_apb_rsp_t;

	typedef struct packed {
		logic a_sense;
		logic v_sense;
		logic v_pvc;
	} prh_sense_t;

endpackage : prh_pkg
